// ===== src/scan_framer_pkg.sv
// Purpose: Shared constants and types for the express scan packet framer
// Assumes: 32-bit AHB-Lite register access, one 200 MHz clock
// Notes: Cabin and header byte counts and sync nibbles are defined here once
package scan_framer_pkg;

  // Packet geometry
  localparam int CABINS_PER_PACKET = 16;
  localparam int BYTES_PER_CABIN = 5;
  localparam int HEADER_BYTES = 4;
  localparam int PACKET_BYTES = HEADER_BYTES + CABINS_PER_PACKET * BYTES_PER_CABIN;
  localparam int CABIN_BITS = 8 * BYTES_PER_CABIN;
  localparam int BANKS = 2;
  localparam int STORE_DEPTH = BANKS * CABINS_PER_PACKET;
  localparam int STORE_ADDR_BITS = $clog2(STORE_DEPTH);
  localparam logic [3:0] LAST_CABIN = 4'hf;
  localparam logic [2:0] LAST_CABIN_BYTE = 3'h4;

  // Sample fields
  localparam int RANGE_BITS = 14;
  localparam int COMP_BITS = 6;
  localparam int ANGLE_BITS = 15;

  // Fixed sync nibbles
  localparam logic [3:0] FIRST_SYNC_NIBBLE = 4'ha;
  localparam logic [3:0] SECOND_SYNC_NIBBLE = 4'h5;

  // Mode value that selects the legacy packet format
  localparam logic [7:0] LEGACY_MODE = 8'h00;

  // Register byte offsets
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] PACKET_COUNT_OFS = 8'h0c;
  localparam logic [7:0] LAST_CHECK_OFS = 8'h10;

  // Control bits (write one to act)
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // Status bits
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_LEGACY_BIT = 1;
  localparam int STAT_UNSUPPORTED_BIT = 2;
  localparam int STAT_BANK0_BIT = 3;
  localparam int STAT_BANK1_BIT = 4;
  localparam int STAT_NEW_PENDING_BIT = 5;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_FIRST_SYNC_NIBBLE,
    TX_ANGLE0,
    TX_ANGLE1,
    TX_CABIN
  } tx_state_e;

endpackage

// ===== src/sample_store.sv
// Purpose: Two-bank cabin store, one write port and one registered read port
// Assumes: Read data holds until the next enabled read
// Notes: No reset on the array; contents are written before they are read
`timescale 1ns/1ps
module sample_store #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 32,
  parameter int ADDR_BITS = 5
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_BITS-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_BITS-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ===== src/cabin_pack.sv
// Purpose: Packs two samples into one five-byte cabin and folds its bytes
// Assumes: First inputs are the earlier sample
// Notes: Byte 0 of the cabin sits in the low eight bits of the word
`timescale 1ns/1ps
module cabin_pack
  import scan_framer_pkg::*;
(
  input wire logic [scan_framer_pkg::RANGE_BITS-1:0] first_sample_range,
  input wire logic [scan_framer_pkg::COMP_BITS-1:0] first_sample_comp,
  input wire logic [scan_framer_pkg::RANGE_BITS-1:0] second_sample_range,
  input wire logic [scan_framer_pkg::COMP_BITS-1:0] second_sample_comp,
  output logic [scan_framer_pkg::CABIN_BITS-1:0] cabin_word,
  output logic [7:0] cabin_xor
);

  // Range in mm passes unchanged so zero stays the invalid marker
  // Compensation is two's complement q3, its top bit the sign
  always_comb begin
    cabin_word = {first_sample_comp[3:0], second_sample_comp[3:0],
                  second_sample_range[13:6],
                  second_sample_range[5:0], second_sample_comp[5:4],
                  first_sample_range[13:6],
                  first_sample_range[5:0], first_sample_comp[5:4]};
    cabin_xor = cabin_word[7:0] ^ cabin_word[15:8] ^ cabin_word[23:16]
              ^ cabin_word[31:24] ^ cabin_word[39:32];
  end

endmodule

// ===== src/scan_framer.sv
// Purpose: Frames measurement samples into legacy express scan packets
// Assumes: A UART transmitter drains tx bytes; AHB-Lite reaches the registers
// Notes: Two banks let one packet fill while the other is sent
// Notes on behaviour
// - Packets follow back to back while scanning
// - Sixteen cabins after the header fields
// - Five-byte cabin holds two samples
// - Sync nibbles 0xA then 0x5 in header
// - Reference angle is unsigned q6 degrees
// - Header carries one new-scan flag bit
// - Flag only on first packet after start
// - Check byte is XOR of data bytes
// - Check excludes both sync-bearing header bytes
// - Range in mm, zero means invalid
// - Compensation signed q3, top bit sign
// - First slot earlier, second slot later
// - Legacy format only when mode is zero
`timescale 1ns/1ps
module scan_framer
  import scan_framer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Samples from the measurement core
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [scan_framer_pkg::RANGE_BITS-1:0] sample_range,
  input wire logic [scan_framer_pkg::COMP_BITS-1:0] sample_comp,
  input wire logic [scan_framer_pkg::ANGLE_BITS-1:0] sample_angle,
  // Byte stream to the UART
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);

  import scan_framer_pkg::*;

  typedef struct packed {
    logic running;
    logic new_pending;
    logic [7:0] req_mode;
    logic fill_bank;
    logic [3:0] fill_cabin;
    logic half;
    logic [RANGE_BITS-1:0] held_range;
    logic [COMP_BITS-1:0] held_comp;
    logic [7:0] fill_chk;
    logic [ANGLE_BITS-1:0] fill_angle;
    logic fill_new;
    logic [BANKS-1:0] bank_full;
    logic [BANKS-1:0][7:0] bank_chk;
    logic [BANKS-1:0][ANGLE_BITS-1:0] bank_angle;
    logic [BANKS-1:0] bank_new;
    tx_state_e tx_state;
    logic tx_bank;
    logic [3:0] tx_cabin;
    logic [2:0] tx_pos;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [15:0] pkt_count;
    logic [7:0] last_chk;
    logic a_write;
    logic [7:0] a_ofs;
    logic [31:0] hrdata;
  } state_s;

  state_s st;
  state_s next_st;

  logic legacy_active;
  logic accept;
  logic tx_load;
  logic mem_we;
  logic [STORE_ADDR_BITS-1:0] mem_waddr;
  logic mem_re;
  logic [STORE_ADDR_BITS-1:0] mem_raddr;
  logic [CABIN_BITS-1:0] mem_rdata;
  logic [CABIN_BITS-1:0] cabin_word;
  logic [7:0] cabin_xor;
  logic [7:0] pkt_chk;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic addr_phase;

  // Cabin builder from the held sample and the incoming one
  cabin_pack u_pack (
    .first_sample_range(st.held_range),
    .first_sample_comp(st.held_comp),
    .second_sample_range(sample_range),
    .second_sample_comp(sample_comp),
    .cabin_word(cabin_word),
    .cabin_xor(cabin_xor)
  );

  // Cabin store, bank in the top address bit
  sample_store #(
    .WIDTH(CABIN_BITS),
    .DEPTH(STORE_DEPTH),
    .ADDR_BITS(STORE_ADDR_BITS)
  ) u_store (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(cabin_word),
    .rd_en(mem_re),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // Handshake and bus terms
  always_comb begin
    legacy_active = st.running && (st.req_mode == LEGACY_MODE);
    sample_ready = !legacy_active || !st.bank_full[st.fill_bank];
    accept = sample_valid && sample_ready && legacy_active;
    tx_load = !st.tx_valid || tx_ready;
    addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
    mem_we = accept && st.half;
    mem_waddr = {st.fill_bank, st.fill_cabin};
    pkt_chk = st.bank_chk[st.tx_bank];
  end

  // Status and read mux
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_RUNNING_BIT] = st.running;
    status_word[STAT_LEGACY_BIT] = legacy_active;
    status_word[STAT_UNSUPPORTED_BIT] = st.running && (st.req_mode != LEGACY_MODE);
    status_word[STAT_BANK0_BIT] = st.bank_full[0];
    status_word[STAT_BANK1_BIT] = st.bank_full[1];
    status_word[STAT_NEW_PENDING_BIT] = st.new_pending;
    case (haddr[7:0])
      MODE_OFS: read_word = {24'h00_0000, st.req_mode};
      STATUS_OFS: read_word = status_word;
      PACKET_COUNT_OFS: read_word = {16'h0000, st.pkt_count};
      LAST_CHECK_OFS: read_word = {24'h00_0000, st.last_chk};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // Next state: fill side, transmit side, then register writes
  always_comb begin
    next_st = st;
    mem_re = 1'b0;
    mem_raddr = {st.tx_bank, st.tx_cabin};

    // Fill: pair samples into cabins, fold check byte, close bank after 16
    if (accept) begin
      if (!st.half) begin
        next_st.held_range = sample_range;
        next_st.held_comp = sample_comp;
        next_st.half = 1'b1;
        if (st.fill_cabin == 4'h0) begin
          next_st.fill_angle = sample_angle;
          next_st.fill_new = st.new_pending;
          next_st.new_pending = 1'b0;
          next_st.fill_chk = 8'h00;
        end
      end else begin
        next_st.half = 1'b0;
        next_st.fill_chk = st.fill_chk ^ cabin_xor;
        if (st.fill_cabin == LAST_CABIN) begin
          next_st.bank_full[st.fill_bank] = 1'b1;
          next_st.bank_chk[st.fill_bank] = st.fill_chk ^ cabin_xor
            ^ st.fill_angle[7:0] ^ {st.fill_new, st.fill_angle[14:8]};
          next_st.bank_angle[st.fill_bank] = st.fill_angle;
          next_st.bank_new[st.fill_bank] = st.fill_new;
          next_st.fill_bank = !st.fill_bank;
          next_st.fill_cabin = 4'h0;
        end else begin
          next_st.fill_cabin = st.fill_cabin + 4'h1;
        end
      end
    end

    // Transmit: byte taken clears valid unless a new byte is loaded
    if (st.tx_valid && tx_ready) begin
      next_st.tx_valid = 1'b0;
    end
    case (st.tx_state)
      TX_IDLE: begin
        if (tx_load && st.bank_full[st.tx_bank]) begin
          next_st.tx_data = {FIRST_SYNC_NIBBLE, pkt_chk[3:0]};
          next_st.tx_valid = 1'b1;
          next_st.tx_state = TX_FIRST_SYNC_NIBBLE;
        end
      end
      TX_FIRST_SYNC_NIBBLE: begin
        if (tx_load) begin
          next_st.tx_data = {SECOND_SYNC_NIBBLE, pkt_chk[7:4]};
          next_st.tx_valid = 1'b1;
          next_st.tx_state = TX_ANGLE0;
        end
      end
      TX_ANGLE0: begin
        if (tx_load) begin
          next_st.tx_data = st.bank_angle[st.tx_bank][7:0];
          next_st.tx_valid = 1'b1;
          next_st.tx_state = TX_ANGLE1;
        end
      end
      TX_ANGLE1: begin
        if (tx_load) begin
          next_st.tx_data = {st.bank_new[st.tx_bank],
                             st.bank_angle[st.tx_bank][14:8]};
          next_st.tx_valid = 1'b1;
          next_st.tx_cabin = 4'h0;
          next_st.tx_pos = 3'h0;
          mem_re = 1'b1;
          mem_raddr = {st.tx_bank, 4'h0};
          next_st.tx_state = TX_CABIN;
        end
      end
      TX_CABIN: begin
        if (tx_load) begin
          next_st.tx_data = mem_rdata[8*st.tx_pos +: 8];
          next_st.tx_valid = 1'b1;
          if (st.tx_pos == LAST_CABIN_BYTE) begin
            next_st.tx_pos = 3'h0;
            if (st.tx_cabin == LAST_CABIN) begin
              next_st.bank_full[st.tx_bank] = 1'b0;
              next_st.tx_bank = !st.tx_bank;
              next_st.pkt_count = st.pkt_count + COUNT_STEP;
              next_st.last_chk = pkt_chk;
              next_st.tx_state = TX_IDLE;
            end else begin
              next_st.tx_cabin = st.tx_cabin + 4'h1;
              mem_re = 1'b1;
              mem_raddr = {st.tx_bank, st.tx_cabin + 4'h1};
            end
          end else begin
            next_st.tx_pos = st.tx_pos + 3'h1;
          end
        end
      end
      default: begin
        next_st.tx_state = TX_IDLE;
      end
    endcase

    // Bus address phase: latch write intent, prepare read data
    next_st.a_write = addr_phase && hwrite;
    next_st.a_ofs = haddr[7:0];
    if (addr_phase && !hwrite) begin
      next_st.hrdata = read_word;
    end

    // Bus data phase writes; start and stop win over the fill path
    if (st.a_write) begin
      case (st.a_ofs)
        CONTROL_OFS: begin
          if (hwdata[CTRL_START_BIT]) begin
            next_st.running = 1'b1;
            next_st.new_pending = 1'b1;
            next_st.fill_cabin = 4'h0;
            next_st.half = 1'b0;
          end else if (hwdata[CTRL_STOP_BIT]) begin
            next_st.running = 1'b0;
            next_st.fill_cabin = 4'h0;
            next_st.half = 1'b0;
          end
        end
        MODE_OFS: begin
          next_st.req_mode = hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign tx_valid = st.tx_valid;
  assign tx_data = st.tx_data;

endmodule

// ===== sim/scan_framer_checker.sv
// Purpose: Port assertions for scan_framer
// Assumes: One clock, sync active-high reset
// Notes: Helper logic tracks the byte position inside each packet
`timescale 1ns/1ps
module scan_framer_checker
  import scan_framer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic sample_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic [6:0] pos;
  logic [7:0] hdr, acc, lo, mode;
  logic seen, ctl_wr, mode_wr;
  wire take = tx_valid && tx_ready;
  wire addr_wr = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Byte position, header check byte, running XOR and tracked writes
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= 7'h00;
      seen <= 1'b0;
      ctl_wr <= 1'b0;
      mode_wr <= 1'b0;
      mode <= 8'h00;
    end else begin
      ctl_wr <= addr_wr && haddr[7:0] == CONTROL_OFS;
      mode_wr <= addr_wr && haddr[7:0] == MODE_OFS;
      if (mode_wr) mode <= hwdata[7:0];
      if (ctl_wr && hwdata[CTRL_START_BIT]) seen <= 1'b0;
      if (take) begin
        pos <= (pos == 7'd83) ? 7'h00 : pos + 7'h01;
        if (pos == 7'd0) hdr[3:0] <= tx_data[3:0];
        if (pos == 7'd1) hdr[7:4] <= tx_data[3:0];
        if (pos == 7'd2) lo <= tx_data;
        acc <= (pos == 7'd2) ? tx_data : acc ^ tx_data;
        if (pos == 7'd3 && tx_data[7]) seen <= 1'b1;
      end
    end
  end
  sequence s_held;
    tx_valid && $stable(tx_data);
  endsequence
  a_tx_holds: assert property (
    tx_valid && !tx_ready |=> s_held) else $error("tx byte changed before taken");
  a_sync_first: assert property (
    tx_valid && pos == 7'd0 |-> tx_data[7:4] == FIRST_SYNC_NIBBLE) else $error("bad sync one");
  a_sync_second: assert property (
    tx_valid && pos == 7'd1 |-> tx_data[7:4] == SECOND_SYNC_NIBBLE) else $error("bad sync two");
  a_check_match: assert property (
    take && pos == 7'd83 |-> (acc ^ tx_data) == hdr) else $error("check byte wrong");
  a_angle_range: assert property (
    take && pos == 7'd3 |-> {tx_data[6:0], lo} < 15'd23040) else $error("angle out of range");
  a_flag_once: assert property (
    take && pos == 7'd3 && tx_data[7] |-> !seen) else $error("new-scan flag repeated");
  a_packet_steady: assert property (
    pos != 7'd0 |-> tx_valid) else $error("gap inside packet");
  a_mode_ready: assert property (
    mode != LEGACY_MODE |-> sample_ready) else $error("stall in unsupported mode");
endmodule
bind scan_framer scan_framer_checker i_scan_framer_checker (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .sample_ready(sample_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data)
);

// ===== sim/host_model.sv
// Purpose: Host receiver model for the framer byte stream
// Assumes: Stalls at random while slow is high
// Notes: Hunts for sync nibbles and verifies the check byte
`timescale 1ns/1ps
module host_model
  import scan_framer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output int good_pkts,
  output int bad_pkts,
  output int turns
);
  int seed_host = 32'h0321;
  int pos;
  logic [7:0] chk, acc, lo;
  logic [14:0] prev, ang;
  // Take bytes, verify each packet, count turns
  always @(posedge clk) begin
    if (rst) begin
      pos = 0;
      prev = 15'h0;
      good_pkts <= 0;
      bad_pkts <= 0;
      turns <= 0;
    end else if (tx_valid && tx_ready) begin
      case (pos)
        0: chk[3:0] = tx_data[3:0];
        1: chk[7:4] = tx_data[3:0];
        2: lo = tx_data;
        3: ang = {tx_data[6:0], lo};
        default: ;
      endcase
      acc = (pos == 2) ? tx_data : acc ^ tx_data;
      if (pos == 3 && ang < prev) turns <= turns + 1;
      if (pos == 3) prev = ang;
      pos = pos + 1;
      if (pos == 1 && tx_data[7:4] != FIRST_SYNC_NIBBLE) pos = 0;
      if (pos == 2 && tx_data[7:4] != SECOND_SYNC_NIBBLE) pos = 0;
      if (pos == PACKET_BYTES) begin
        pos = 0;
        if (acc == chk) good_pkts <= good_pkts + 1;
        else bad_pkts <= bad_pkts + 1;
      end
    end
    tx_ready <= !rst && (!slow || ($random(seed_host) & 3) == 0);
  end
endmodule

// ===== sim/test_scan_framer.sv
// Purpose: Self-checking bench for scan_framer
// Assumes: 200 MHz clock, host model drains the byte stream
// Notes: Expected bytes are built from the samples the bench sends
`timescale 1ns/1ps
module test_scan_framer;
  import scan_framer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, sample_ready, tx_valid, tx_ready;
  logic [31:0] hrdata, rd;
  logic sample_valid = 1'b0;
  logic slow = 1'b0;
  logic [RANGE_BITS-1:0] sample_range = '0;
  logic [COMP_BITS-1:0] sample_comp = '0;
  logic [ANGLE_BITS-1:0] sample_angle = '0;
  logic [7:0] tx_data, last_chk;
  logic [7:0] exp_q[$];
  int good_pkts, bad_pkts, turns;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h7bd8;
  assign hready = hreadyout;
  always #2.5 clk = ~clk;
  scan_framer i_scan_framer (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_range(sample_range), .sample_comp(sample_comp),
    .sample_angle(sample_angle), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  host_model i_host_model (.clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .good_pkts(good_pkts), .bad_pkts(bad_pkts),
    .turns(turns));
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up(input string what);
    num_errors++;
    $display("[FAIL] %0t timeout %s", $time, what);
    wrap_up();
  endtask
  // Wait for an edge with hready high
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) give_up("bus");
  endtask
  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask
  task automatic reg_is(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    bus(1'b0, ofs, 32'h0);
    check(rd, exp, what);
  endtask
  // Offer samples; when a packet is due, queue its expected bytes
  task automatic send(input int cnt, input logic [14:0] ang, input logic mark, input logic pkt);
    logic [13:0] r[32];
    logic [5:0] c[32];
    logic [7:0] b[84];
    int n;
    for (int i = 0; i < cnt; i++) begin
      r[i] = (i == 5) ? 14'h0 : 14'($random(seed)); // Zero marks an invalid sample
      c[i] = 6'($random(seed));
      sample_valid <= 1'b1;
      sample_range <= r[i];
      sample_comp <= c[i];
      sample_angle <= (i == 0) ? ang : 15'($random(seed));
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (sample_ready !== 1'b1 && n < 2000);
      if (sample_ready !== 1'b1) give_up("sample");
    end
    sample_valid <= 1'b0;
    if (pkt) begin
      for (int k = 0; k < 16; k++) begin
        b[4+5*k] = {r[2*k][5:0], c[2*k][5:4]};
        b[5+5*k] = r[2*k][13:6];
        b[6+5*k] = {r[2*k+1][5:0], c[2*k+1][5:4]};
        b[7+5*k] = r[2*k+1][13:6];
        b[8+5*k] = {c[2*k][3:0], c[2*k+1][3:0]};
      end
      b[2] = ang[7:0];
      b[3] = {mark, ang[14:8]};
      last_chk = 8'h00;
      for (int k = 2; k < 84; k++) last_chk ^= b[k];
      b[0] = {FIRST_SYNC_NIBBLE, last_chk[3:0]};
      b[1] = {SECOND_SYNC_NIBBLE, last_chk[7:4]};
      for (int k = 0; k < 84; k++) exp_q.push_back(b[k]);
    end
    // Let valid settle low before a following call raises it again
    @(posedge clk);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() > 0) give_up("stream");
  endtask
  // Every byte handed to the host is compared in order
  always @(posedge clk) begin
    if (!rst && tx_valid && tx_ready) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected byte");
      else check({24'h0, tx_data}, {24'h0, exp_q.pop_front()}, "tx byte");
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, a read-only write and an unmapped place
    reg_is(STATUS_OFS, 32'h0, "status");
    reg_is(MODE_OFS, 32'h0, "mode");
    bus(1'b1, STATUS_OFS, 32'hffff_ffff);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    reg_is(8'h20, 32'h0, "unmapped");
    reg_is(STATUS_OFS, 32'h0, "status ro");
    // Start, then three packets back to back, host stalling at first
    slow <= 1'b1;
    bus(1'b1, CONTROL_OFS, 32'h1);
    reg_is(STATUS_OFS, 32'h23, "armed");
    send(32, 15'd22000, 1'b1, 1'b1);
    send(32, 15'd23000, 1'b0, 1'b1);
    slow <= 1'b0;
    send(32, 15'd100, 1'b0, 1'b1);
    drain();
    reg_is(PACKET_COUNT_OFS, 32'h3, "count");
    reg_is(LAST_CHECK_OFS, {24'h0, last_chk}, "last check");
    reg_is(STATUS_OFS, 32'h3, "running");
    check(turns, 32'h1, "turns");
    // Nonzero mode drops samples and sends nothing
    bus(1'b1, MODE_OFS, 32'h1);
    reg_is(STATUS_OFS, 32'h5, "unsupported");
    send(32, 15'd300, 1'b0, 1'b0);
    bus(1'b1, MODE_OFS, 32'h0);
    // Stop drops a partial fill; restart flags a new scan again
    send(10, 15'd400, 1'b0, 1'b0);
    bus(1'b1, CONTROL_OFS, 32'h2);
    reg_is(STATUS_OFS, 32'h0, "stopped");
    bus(1'b1, CONTROL_OFS, 32'h1);
    send(32, 15'd500, 1'b1, 1'b1);
    drain();
    reg_is(PACKET_COUNT_OFS, 32'h4, "count four");
    check(good_pkts, 32'h4, "host good");
    check(bad_pkts, 32'h0, "host bad");
    wrap_up();
  end
endmodule
